// >>> design/sptc_pkg.sv
// sptc_pkg: constants for the serial programming command interpreter
// assumes: gear clock drives the block, latencies counted in its cycles
`default_nettype none
package sptc_pkg;
  // ****************************************
  // command and sync codes
  // ****************************************
  localparam logic [7:0] SYNC_A     = 8'h86;
  localparam logic [7:0] SYNC_B     = 8'h79;
  localparam logic [7:0] CMD_WRITE  = 8'h30;
  localparam logic [7:0] CMD_READ   = 8'h40;
  localparam logic [7:0] CMD_SUM    = 8'h90;
  localparam logic [7:0] CMD_ID     = 8'hc0;
  localparam logic [7:0] CMD_STAT   = 8'hc3;
  localparam logic [7:0] CMD_EMUL   = 8'hd0;
  localparam logic [7:0] CMD_ERASE  = 8'hf0;
  localparam logic [7:0] CMD_SECURE = 8'h70;
  localparam logic [7:0] CMD_RSUM   = 8'h60;
  // ****************************************
  // latencies in gear-clock cycles
  // ****************************************
  localparam int LAT_SYNC_A  = 660;
  localparam int LAT_SYNC_B  = 540;
  localparam int LAT_CMD     = 300;
  localparam int LAT_FSUM    = 1493340;
  localparam int LAT_RSUM    = 160;
  localparam int LAT_WR      = 200;
  localparam int LAT_RD      = 430;
  localparam int LAT_EMUL    = 420;
  localparam int LAT_SEC     = 1080;
  localparam int CNT_W       = 21;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    SPTC_IDLE = 3'h0,
    SPTC_WAIT = 3'h1,
    SPTC_SEND = 3'h3,
    SPTC_ARG  = 3'h2,
    SPTC_WORK = 3'h6
  } sptc_state_t;
endpackage : sptc_pkg
`default_nettype wire

// >>> design/sptc_core.sv
// sptc_core: command interpreter for serial programming mode
// assumes: a uart outside delivers received bytes and takes bytes to send
`timescale 1ns/10ps
`default_nettype none
// Function
// - echo 0x86 after 660 cycles
// - echo 0x79 after 540 cycles
// - echo operation command after 300 cycles
// - flash checksum takes 1493340 cycles
// - ram checksum takes 160 cycles
// - write record answer after 200 cycles
// - read data starts after 430 cycles
// - emulation data echo after 420 cycles
// - security enable takes 1080 cycles
// - 0x30 selects flash write
// - 0x40 selects flash read
// - 0x90 selects flash checksum
// - 0xc0 sends product id
// - 0xc3 sends flash status
// - 0xd0 selects emulation setting
// - 0xf0 selects flash erase
module sptc_core #(
  parameter int FSUM_CYCLES = sptc_pkg::LAT_FSUM,
  parameter logic [7:0] PROD_ID = 8'h5a  // arbitrary identification value
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic [2:0]      op_sel,
  output logic            busy,
  output logic            secured
);
  // ****************************************
  // decode
  // ****************************************
  function automatic logic [2:0] op_code(input logic [7:0] b);
    case (b)
      sptc_pkg::CMD_WRITE: op_code = 3'h1;
      sptc_pkg::CMD_READ:  op_code = 3'h2;
      sptc_pkg::CMD_SUM:   op_code = 3'h3;
      sptc_pkg::CMD_ID:    op_code = 3'h4;
      sptc_pkg::CMD_STAT:  op_code = 3'h5;
      sptc_pkg::CMD_EMUL:  op_code = 3'h6;
      sptc_pkg::CMD_ERASE: op_code = 3'h7;
      default:             op_code = 3'h0;
    endcase
  endfunction : op_code

  // ram checksum and security enable also take one argument byte
  function automatic logic [1:0] ext_code(input logic [7:0] b);
    case (b)
      sptc_pkg::CMD_RSUM:   ext_code = 2'h1;
      sptc_pkg::CMD_SECURE: ext_code = 2'h2;
      default:              ext_code = 2'h0;
    endcase
  endfunction : ext_code

  sptc_pkg::sptc_state_t state;
  sptc_pkg::sptc_state_t next_state;
  logic [sptc_pkg::CNT_W-1:0] cnt;
  logic [sptc_pkg::CNT_W-1:0] next_cnt;
  logic [7:0]                 pend;
  logic [7:0]                 next_pend;
  logic [1:0]                 sync_seen;
  logic [2:0]                 next_op;
  logic                       next_secured;
  logic                       take;
  logic                       done;
  logic [2:0]                 rx_op;
  logic [1:0]                 ext_op;
  logic [1:0]                 next_ext;
  logic [1:0]                 rx_ext;

  assign take  = ce && rx_valid && (state == sptc_pkg::SPTC_IDLE || state == sptc_pkg::SPTC_ARG);
  assign rx_op = op_code(rx_data);
  assign rx_ext = ext_code(rx_data);
  assign done  = (cnt == '0);
  assign busy  = (state != sptc_pkg::SPTC_IDLE) && (state != sptc_pkg::SPTC_ARG);

  function automatic logic [sptc_pkg::CNT_W-1:0] lat(input int c);
    lat = sptc_pkg::CNT_W'(c - 1);
  endfunction : lat

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_pend    = pend;
    next_op      = op_sel;
    next_secured = secured;
    next_ext     = ext_op;
    case (state)
      sptc_pkg::SPTC_IDLE: begin
        if (take) begin
          next_pend  = rx_data;
          next_state = sptc_pkg::SPTC_WAIT;
          next_ext   = 2'h0;
          if (sync_seen == 2'h0 && rx_data == sptc_pkg::SYNC_A) begin
            next_cnt = lat(sptc_pkg::LAT_SYNC_A);
          end else if (sync_seen == 2'h1 && rx_data == sptc_pkg::SYNC_B) begin
            next_cnt = lat(sptc_pkg::LAT_SYNC_B);
          end else begin
            next_cnt = lat(sptc_pkg::LAT_CMD);
            next_op  = rx_op;
            next_ext = rx_ext;
          end
        end
      end
      sptc_pkg::SPTC_WAIT, sptc_pkg::SPTC_WORK: begin
        if (ce) begin
          if (done) begin
            next_state = sptc_pkg::SPTC_SEND;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      sptc_pkg::SPTC_SEND: begin
        if (ce && tx_ready) begin
          next_state = (op_sel == 3'h0 && ext_op == 2'h0) ? sptc_pkg::SPTC_IDLE : sptc_pkg::SPTC_ARG;
        end
      end
      sptc_pkg::SPTC_ARG: begin
        if (take) begin
          next_state = sptc_pkg::SPTC_WORK;
          next_op    = 3'h0;
          next_ext   = 2'h0;
          next_pend  = rx_data;
          if (ext_op == 2'h1) begin
            next_cnt  = lat(sptc_pkg::LAT_RSUM);
            next_pend = 8'h00;
          end else if (ext_op == 2'h2) begin
            next_cnt     = lat(sptc_pkg::LAT_SEC);
            next_pend    = 8'h00;
            next_secured = 1'b1;
          end else begin
            case (op_sel)
              3'h1: begin
                next_cnt  = lat(sptc_pkg::LAT_WR);
                next_pend = 8'h00;
              end
              3'h2: next_cnt = lat(sptc_pkg::LAT_RD);
              3'h3: begin
                next_cnt  = sptc_pkg::CNT_W'(FSUM_CYCLES - 1);
                next_pend = 8'h00;
              end
              3'h4: begin
                next_cnt  = lat(sptc_pkg::LAT_CMD);
                next_pend = PROD_ID;
              end
              3'h5: begin
                next_cnt  = lat(sptc_pkg::LAT_CMD);
                next_pend = {7'h00, secured};
              end
              3'h6: next_cnt = lat(sptc_pkg::LAT_EMUL);
              default: begin
                next_cnt     = lat(sptc_pkg::LAT_CMD);
                next_secured = 1'b0;
              end
            endcase
          end
        end
      end
      default: next_state = sptc_pkg::SPTC_IDLE;
    endcase
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= sptc_pkg::SPTC_IDLE;
      cnt     <= '0;
      pend    <= 8'h00;
      op_sel  <= 3'h0;
      secured <= 1'b0;
      ext_op  <= 2'h0;
    end else if (ce) begin
      state   <= next_state;
      cnt     <= next_cnt;
      pend    <= next_pend;
      op_sel  <= next_op;
      secured <= next_secured;
      ext_op  <= next_ext;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_seen <= 2'h0;
    end else if (ce && take && state == sptc_pkg::SPTC_IDLE && sync_seen != 2'h2) begin
      sync_seen <= sync_seen + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_data <= 8'h00;
    end else if (ce && next_state == sptc_pkg::SPTC_SEND && state != sptc_pkg::SPTC_SEND) begin
      tx_data <= pend;
    end
  end

  assign tx_valid = (state == sptc_pkg::SPTC_SEND);

  // ****************************************
  // checks
  // ****************************************
  // ****************************************
  // latency checks
  // ****************************************
  chk_sync_echo: assert property (@(posedge clk) disable iff (!resetn)
    (state == sptc_pkg::SPTC_IDLE && take && sync_seen == 2'h0 && rx_data == sptc_pkg::SYNC_A)
    |=> (!tx_valid) [*8])
    else $error("sync echo too early");

  chk_sync_b_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_IDLE && sync_seen == 2'h1 && rx_data == sptc_pkg::SYNC_B)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_SYNC_B - 1))
    else $error("second sync latency wrong");

  chk_cmd_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_IDLE && rx_op != 3'h0 && sync_seen == 2'h2)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_CMD - 1))
    else $error("command latency wrong");

  chk_write_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h0 && op_sel == 3'h1)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_WR - 1))
    else $error("write record latency wrong");

  chk_read_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h0 && op_sel == 3'h2)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_RD - 1))
    else $error("read latency wrong");

  chk_sum_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h0 && op_sel == 3'h3)
    |=> cnt == sptc_pkg::CNT_W'(FSUM_CYCLES - 1))
    else $error("flash checksum latency wrong");

  chk_emul_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && op_sel == 3'h6)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_EMUL - 1))
    else $error("emulation latency wrong");

  chk_rsum_delay: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h1)
    |=> cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_RSUM - 1))
    else $error("ram checksum latency wrong");

  chk_secure_set: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h2)
    |=> (secured && cnt == sptc_pkg::CNT_W'(sptc_pkg::LAT_SEC - 1)))
    else $error("security enable wrong");

  // ****************************************
  // answer checks
  // ****************************************
  chk_decode_write: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_IDLE && sync_seen == 2'h2 && rx_data == sptc_pkg::CMD_WRITE)
    |=> op_sel == 3'h1)
    else $error("write command not decoded");

  chk_id_value: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h0 && op_sel == 3'h4)
    |=> pend == PROD_ID)
    else $error("identification byte wrong");

  chk_status_value: assert property (@(posedge clk) disable iff (!resetn)
    (take && state == sptc_pkg::SPTC_ARG && ext_op == 2'h0 && op_sel == 3'h5)
    |=> pend == {7'h00, secured})
    else $error("status byte wrong");

  chk_busy_refuse: assert property (@(posedge clk) disable iff (!resetn)
    (busy && rx_valid) |=> $stable(pend))
    else $error("byte taken while busy");

  // ****************************************
  // handshake and clock-enable checks
  // ****************************************
  chk_tx_hold: assert property (@(posedge clk) disable iff (!resetn)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data)))
    else $error("tx dropped before ready");

  chk_freeze_hold: assert property (@(posedge clk) disable iff (!resetn)
    (!ce) |=> ($stable(state) && $stable(cnt) && $stable(tx_data)))
    else $error("state moved with clock enable low");
endmodule : sptc_core
`default_nettype wire

// >>> tb/sptc_host.sv
// sptc_host: model of the programming host's receive side
// assumes: tx_valid/tx_data hold until tx_ready is sampled high
`timescale 1ns/10ps
`default_nettype none
module sptc_host (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] stall,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            got,
  output logic [7:0]      got_data
);
  logic [3:0] cnt;
  // ****************************************
  // accept each byte after a chosen stall
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt      <= 4'h0;
      tx_ready <= 1'b0;
      got      <= 1'b0;
      got_data <= 8'h00;
    end else begin
      got <= 1'b0;
      if (tx_valid && tx_ready) begin
        got      <= 1'b1;
        got_data <= tx_data;
        tx_ready <= 1'b0;
        cnt      <= 4'h0;
      end else if (tx_valid) begin
        if (cnt >= stall) tx_ready <= 1'b1;
        else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : sptc_host
`default_nettype wire

// >>> tb/sptc_core_tb.sv
// sptc_core_tb: self-checking bench for the command interpreter
// assumes: sptc_host takes every byte the block sends
`timescale 1ns/10ps
`default_nettype none
module sptc_core_tb;
  logic clk, resetn, ce, rx_valid, tx_ready, tx_valid, busy, secured, got;
  logic [7:0] rx_data, tx_data, got_data;
  logic [2:0] op_sel;
  logic [3:0] stall;
  int n_mismatch = 0;
  int cmp_count = 0;
  sptc_core #(.FSUM_CYCLES(50), .PROD_ID(8'h5a)) dut (  // id value arbitrary
    .clk(clk), .resetn(resetn), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .op_sel(op_sel), .busy(busy), .secured(secured));
  sptc_host host (.clk(clk), .resetn(resetn), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .got(got), .got_data(got_data));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // send one byte, time the answer, compare it if cmp is set
  task automatic xfer(input logic [7:0] b, input int lat, input logic [7:0] exp, input bit cmp);
    int n;
    n = 0;
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_data = b;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    while (tx_valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    check(8'(n >= lat && n <= lat + 2), 8'h01);
    while (got !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h00, got}, 8'h01);
    if (cmp) check(got_data, exp);
    repeat (1100) @(posedge clk);
  endtask : xfer
  task automatic t_sync;
    check({5'h00, tx_valid, busy, secured}, 8'h00);
    xfer(8'h86, 660, 8'h86, 1'b1);
    xfer(8'h79, 540, 8'h79, 1'b1);
  endtask : t_sync
  task automatic t_cmd(input logic [7:0] c, input logic [7:0] a, input int lat,
                       input logic [7:0] exp, input bit cmp, input int op);
    xfer(c, 300, c, 1'b1);
    if (op >= 0) check({5'h00, op_sel}, 8'(op));
    xfer(a, lat, exp, cmp);
  endtask : t_cmd
  // freeze the count with ce low, offer a byte while busy
  task automatic t_freeze;
    int n;
    n = 0;
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_data = 8'h00;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    ce = 1'b0;
    repeat (50) @(posedge clk);
    #1 ce = 1'b1;
    check({6'h00, tx_valid, busy}, 8'h01);
    rx_valid = 1'b1;
    rx_data = 8'h55;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    n = 1;
    while (tx_valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    check(8'(n == 300), 8'h01);
    while (got !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h00, got}, 8'h01);
    check(got_data, 8'h00);
    repeat (1100) @(posedge clk);
  endtask : t_freeze
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    stall = 4'h0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (20) @(posedge clk);
    t_sync();
    t_freeze();
    t_cmd(8'h30, 8'h11, 200, 8'h00, 1'b1, 1);
    stall = 4'h7;
    t_cmd(8'h40, 8'h04, 430, 8'h00, 1'b0, 2);
    t_cmd(8'h90, 8'h00, 50, 8'h00, 1'b1, 3);
    t_cmd(8'hc0, 8'h00, 300, 8'h5a, 1'b1, 4);
    stall = 4'h0;
    t_cmd(8'h60, 8'h00, 160, 8'h00, 1'b1, -1);
    t_cmd(8'h70, 8'h00, 1080, 8'h00, 1'b0, -1);
    check({7'h00, secured}, 8'h01);
    t_cmd(8'hc3, 8'h00, 300, 8'h01, 1'b1, 5);
    t_cmd(8'hd0, 8'h3c, 420, 8'h3c, 1'b1, 6);
    t_cmd(8'hf0, 8'h00, 300, 8'h00, 1'b0, 7);
    check({7'h00, secured}, 8'h00);
    t_cmd(8'hc3, 8'h00, 300, 8'h00, 1'b1, 5);
    give_verdict();
  end
endmodule : sptc_core_tb
`default_nettype wire
